//--- switch_cfg_pkg.sv
// Overview of operation
// - Each GPIO pin has enable; resets input.
// - Drive pin with value only when enabled.
// - Input bit shows live pin level always.
// - Pin n uses bits 4n to 4n+3.
// - GPIO register exists on upstream port only.
// - Bit 20 globally disables clocks; strap default.
// - Bits 19:16 enable each clock; reset Fh.
// - Capability header reads 0Dh, next C0h.
// - Subsystem vendor/device codes share word, zero.
// - Read-only fields accept loaded default values.
// - Ordering-freeze-disable bit stops relaxed-ordering rule.
// - Bit 10 disables port; loadable only.
// - Reset select acts on upstream port only.
// - Bits 9:8 set rate change attempts.
// - Bits 23:16 hold extra PHY byte, 79h.
// - Mode word low half reports strap flags.
// - Equaliser byte 86h upstream, 00h downstream.
// - Word three: lane mode zero, delta one.
package switch_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int GPIO_N = 8;
  localparam int MODE_PIN_N = 9;
  localparam int REFCLK_N = 4;

  localparam logic [ADDR_W-1:0] OFF_TL_CTRL = 8'h8c;
  localparam logic [ADDR_W-1:0] OFF_PHY3 = 8'h90;
  localparam logic [ADDR_W-1:0] OFF_PHY4 = 8'h94;
  localparam logic [ADDR_W-1:0] OFF_OPMODE = 8'h98;
  localparam logic [ADDR_W-1:0] OFF_SUBSYS_CAP = 8'hb0;
  localparam logic [ADDR_W-1:0] OFF_SUBSYS_ID = 8'hb4;
  localparam logic [ADDR_W-1:0] OFF_GPIO = 8'hb8;

  localparam logic [31:0] TL_RESET = 32'h0079_0010;
  localparam logic [31:0] TL_IMPL_MASK = 32'hbfff_1fff;
  localparam logic [31:0] TL_SW_MASK = 32'h0000_0060;
  localparam int TL_ORDER_FREEZE_BIT = 6;
  localparam int TL_RATE_CNT_LSB = 8;
  localparam int TL_PORT_DISABLE_BIT = 10;
  localparam int TL_RESET_SEL_BIT = 11;
  localparam int TL_EXTRA_PHY_LSB = 16;

  localparam logic [31:0] PHY3_RESET = 32'h0000_8000;
  localparam logic [31:0] PHY3_IMPL_MASK = 32'hffff_807f;
  localparam logic [31:0] PHY4_RESET_UP = 32'h0086_116b;
  localparam logic [31:0] PHY4_RESET_DOWN = 32'h0000_116b;
  localparam logic [31:0] PHY4_MASK_UP = 32'h00ff_ffff;
  localparam logic [31:0] PHY4_MASK_DOWN = 32'h0000_ffff;

  localparam int CLKBUF_EN_LSB = 16;
  localparam int CLOCK_BUFFER_POWERDOWN_STRAP_BIT = 20;
  localparam logic [REFCLK_N-1:0] CLKBUF_EN_RESET = 4'hf;
  localparam logic [31:0] OPMODE_LOAD_MASK = 32'h001f_0000;

  localparam logic [7:0] SUBSYS_CAP_ID = 8'h0d;
  localparam logic [7:0] SUBSYS_NEXT_PTR = 8'hc0;
  localparam logic [31:0] SUBSYS_ID_RESET = 32'h0000_0000;

  localparam int GPIO_IN_POS = 0;
  localparam int GPIO_OE_POS = 1;
  localparam int GPIO_VAL_POS = 2;
  localparam logic [GPIO_N-1:0] GPIO_OE_RESET = 8'h00;
  localparam logic [GPIO_N-1:0] GPIO_VAL_RESET = 8'h00;
endpackage

//--- gpio_pins_if.sv
`timescale 1ns/1ps
interface gpio_pins_if #(parameter int N = 8);
  logic [N-1:0] oe;
  logic [N-1:0] val;
  logic [N-1:0] level;
  modport regs (output oe, output val, input level);
  modport pins (input oe, input val, output level);
endinterface

//--- gpio_pin_driver.sv
`timescale 1ns/1ps
module gpio_pin_driver #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  gpio_pins_if.pins ctrl,
  input wire logic [N-1:0] gpioPinIn,
  output logic [N-1:0] gpioPinOut,
  output logic [N-1:0] gpioPinOe
);
  logic [N-1:0] pinMeta_reg;
  logic [N-1:0] pinSync_reg;

  // Every per-pin vector needs at least one bit
  if (N < 1) begin : pinCountCheck
    $error("gpio_pin_driver needs at least one pin");
  end

  // Pins are asynchronous to clk; the first stage is read by the second only
  always_ff @(posedge clk) begin
    pinMeta_reg <= gpioPinIn;
    pinSync_reg <= pinMeta_reg;
  end

  assign ctrl.level = pinSync_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gpioPinOe <= '0;
      gpioPinOut <= '0;
    end else begin
      gpioPinOe <= ctrl.oe;
      // Value is forced low while undriven so nothing leaks through the pad
      gpioPinOut <= ctrl.val & ctrl.oe;
    end
  end
endmodule

//--- switch_port_config_gpio_regs.sv
`timescale 1ns/1ps
module switch_port_config_gpio_regs
  #(
  parameter bit IS_UPSTREAM = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cfgReq,
  input wire logic cfgWrite,
  input wire logic [switch_cfg_pkg::ADDR_W-1:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWdata,
  output logic [31:0] cfgRdata,
  output logic cfgAck,
  input wire logic defaultLoad,
  input wire logic [switch_cfg_pkg::ADDR_W-1:0] defaultAddr,
  input wire logic [31:0] defaultData,
  input wire logic clockBufferPowerdownStrap,
  input wire logic [switch_cfg_pkg::MODE_PIN_N-1:0] modePins,
  input wire logic [switch_cfg_pkg::GPIO_N-1:0] gpioPinIn,
  output logic [switch_cfg_pkg::GPIO_N-1:0] gpioPinOut,
  output logic [switch_cfg_pkg::GPIO_N-1:0] gpioPinOe,
  output logic [switch_cfg_pkg::REFCLK_N-1:0] refClkOutEnable,
  output logic portDisable,
  output logic relaxedOrderingOff,
  output logic resetSelect,
  output logic [1:0] rateChangeAttemptCount,
  output logic [7:0] extraPhyControlByte
);
  import switch_cfg_pkg::*;

  // Merge write data under byte enables, limited to the bits that may change
  function automatic logic [31:0] mergeWrite(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [31:0] mask
  );
    logic [31:0] laneMask;
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    return (old & ~laneMask) | (wdata & laneMask);
  endfunction

  // One strobe qualified by one address match
  function automatic logic hitOffset(
    input logic strobe,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    return strobe && (addr == offset);
  endfunction

  localparam logic [31:0] PHY4_RESET = IS_UPSTREAM ? PHY4_RESET_UP : PHY4_RESET_DOWN;
  localparam logic [31:0] PHY4_MASK = IS_UPSTREAM ? PHY4_MASK_UP : PHY4_MASK_DOWN;

  // The read words below are built for exactly these field sizes
  if (4 * GPIO_N != 32) begin : gpioFitCheck
    $error("GPIO groups must fill one register word");
  end
  if (REFCLK_N != CLOCK_BUFFER_POWERDOWN_STRAP_BIT - CLKBUF_EN_LSB) begin : clkFieldCheck
    $error("clock enable field must reach the global disable bit");
  end
  if (MODE_PIN_N != 9) begin : modeFitCheck
    $error("mode word layout assumes nine mode pins");
  end

  gpio_pins_if #(.N(GPIO_N)) gpioBus ();

  logic [31:0] tlCtrl_reg;
  logic [31:0] phy3_reg;
  logic [31:0] phy4_reg;
  logic [REFCLK_N-1:0] clkBufEn_reg;
  logic clkBufPd_reg;
  logic [31:0] subsysId_reg;
  logic [GPIO_N-1:0] gpioOe_reg;
  logic [GPIO_N-1:0] gpioVal_reg;
  logic strapMeta_reg;
  logic strapSync_reg;
  logic [MODE_PIN_N-1:0] modeMeta_reg;
  logic [MODE_PIN_N-1:0] modeSync_reg;
  logic swWrite;
  logic [31:0] gpioWord;
  logic [31:0] opmodeWord;
  logic [31:0] readWord;
  logic strapHold_reg;
  logic loadTl;
  logic loadPhy3;
  logic loadPhy4;
  logic loadOpmode;
  logic loadSubsys;
  logic writeTl;
  logic writeGpio;

  assign swWrite = cfgReq & cfgWrite;
  assign loadTl = hitOffset(defaultLoad, defaultAddr, OFF_TL_CTRL);
  assign loadPhy3 = hitOffset(defaultLoad, defaultAddr, OFF_PHY3);
  assign loadPhy4 = hitOffset(defaultLoad, defaultAddr, OFF_PHY4);
  assign loadOpmode = hitOffset(defaultLoad, defaultAddr, OFF_OPMODE);
  assign loadSubsys = hitOffset(defaultLoad, defaultAddr, OFF_SUBSYS_ID);
  assign writeTl = hitOffset(swWrite, cfgAddr, OFF_TL_CTRL);
  assign writeGpio = hitOffset(swWrite, cfgAddr, OFF_GPIO);

  // Strap and mode pins come from outside the clock domain
  always_ff @(posedge clk) begin
    strapMeta_reg <= clockBufferPowerdownStrap;
    strapSync_reg <= strapMeta_reg;
  end

  always_ff @(posedge clk) begin
    modeMeta_reg <= modePins;
    modeSync_reg <= modeMeta_reg;
  end

  // Default loading writes every implemented bit; software only the writable ones
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tlCtrl_reg <= TL_RESET;
    end else if (loadTl) begin
      tlCtrl_reg <= defaultData & TL_IMPL_MASK;
    end else if (writeTl) begin
      tlCtrl_reg <= mergeWrite(tlCtrl_reg, cfgWdata, cfgByteEn, TL_SW_MASK);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy3_reg <= PHY3_RESET;
    end else if (loadPhy3) begin
      phy3_reg <= defaultData & PHY3_IMPL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phy4_reg <= PHY4_RESET;
    end else if (loadPhy4) begin
      phy4_reg <= defaultData & PHY4_MASK;
    end
  end

  // The strap is taken once more on the first clock after reset, so a short
  // reset still leaves the synchronised pin level in the register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strapHold_reg <= 1'b1;
    end else begin
      strapHold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkBufPd_reg <= strapSync_reg;
    end else if (loadOpmode) begin
      clkBufPd_reg <= defaultData[CLOCK_BUFFER_POWERDOWN_STRAP_BIT];
    end else if (strapHold_reg) begin
      clkBufPd_reg <= strapSync_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkBufEn_reg <= CLKBUF_EN_RESET;
    end else if (loadOpmode) begin
      clkBufEn_reg <= defaultData[CLKBUF_EN_LSB +: REFCLK_N];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      subsysId_reg <= SUBSYS_ID_RESET;
    end else if (loadSubsys) begin
      subsysId_reg <= defaultData;
    end
  end

  // Downstream ports have no GPIO register: state stays at reset
  always_ff @(posedge clk) begin
    if (sys_rst || !IS_UPSTREAM) begin
      gpioOe_reg <= GPIO_OE_RESET;
    end else begin
      for (int n = 0; n < GPIO_N; n++) begin
        if (writeGpio && cfgByteEn[n/2]) begin
          gpioOe_reg[n] <= cfgWdata[4*n + GPIO_OE_POS];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !IS_UPSTREAM) begin
      gpioVal_reg <= GPIO_VAL_RESET;
    end else begin
      for (int n = 0; n < GPIO_N; n++) begin
        if (writeGpio && cfgByteEn[n/2]) begin
          gpioVal_reg[n] <= cfgWdata[4*n + GPIO_VAL_POS];
        end
      end
    end
  end

  assign gpioBus.oe = gpioOe_reg;
  assign gpioBus.val = gpioVal_reg;

  gpio_pin_driver #(.N(GPIO_N)) pinDriver (
    .clk(clk),
    .sys_rst(sys_rst),
    .ctrl(gpioBus.pins),
    .gpioPinIn(gpioPinIn),
    .gpioPinOut(gpioPinOut),
    .gpioPinOe(gpioPinOe)
  );

  genvar g;
  generate
    for (g = 0; g < GPIO_N; g++) begin : gpioField
      assign gpioWord[4*g + GPIO_IN_POS] = gpioBus.level[g];
      assign gpioWord[4*g + GPIO_OE_POS] = gpioOe_reg[g];
      assign gpioWord[4*g + GPIO_VAL_POS] = gpioVal_reg[g];
      assign gpioWord[4*g + 3] = 1'b0;
    end
  endgenerate

  // Low half: seven zeros, scan, package select, then the seven flags
  assign opmodeWord = {11'h000, clkBufPd_reg, clkBufEn_reg, 7'h00, modeSync_reg};

  always_comb begin
    case (cfgAddr)
      OFF_TL_CTRL: readWord = tlCtrl_reg;
      OFF_PHY3: readWord = phy3_reg;
      OFF_PHY4: readWord = phy4_reg;
      OFF_OPMODE: readWord = opmodeWord;
      OFF_SUBSYS_CAP: readWord = {16'h0000, SUBSYS_NEXT_PTR, SUBSYS_CAP_ID};
      OFF_SUBSYS_ID: readWord = subsysId_reg;
      OFF_GPIO: readWord = IS_UPSTREAM ? gpioWord : 32'h0000_0000;
      default: readWord = 32'h0000_0000;
    endcase
  end

  // Every access completes in one cycle; writes read back zero data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgAck <= 1'b0;
    end else begin
      cfgAck <= cfgReq;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgRdata <= 32'h0000_0000;
    end else begin
      cfgRdata <= (cfgReq && !cfgWrite) ? readWord : 32'h0000_0000;
    end
  end

  // Control outputs lag their register by one clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refClkOutEnable <= '0;
    end else begin
      refClkOutEnable <= clkBufEn_reg & {REFCLK_N{~clkBufPd_reg}};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      portDisable <= 1'b0;
    end else begin
      portDisable <= tlCtrl_reg[TL_PORT_DISABLE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      relaxedOrderingOff <= 1'b0;
    end else begin
      relaxedOrderingOff <= tlCtrl_reg[TL_ORDER_FREEZE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resetSelect <= 1'b0;
    end else begin
      resetSelect <= IS_UPSTREAM & tlCtrl_reg[TL_RESET_SEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rateChangeAttemptCount <= 2'h0;
    end else begin
      rateChangeAttemptCount <= tlCtrl_reg[TL_RATE_CNT_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extraPhyControlByte <= 8'h00;
    end else begin
      extraPhyControlByte <= tlCtrl_reg[TL_EXTRA_PHY_LSB +: 8];
    end
  end
endmodule

//--- switch_port_config_gpio_regs_sva.sv
`timescale 1ns/1ps
module switch_port_config_gpio_regs_chk #(parameter bit IS_UPSTREAM = 1'b1) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cfgReq,
  input wire logic cfgWrite,
  input wire logic [switch_cfg_pkg::ADDR_W-1:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWdata,
  input wire logic [31:0] cfgRdata,
  input wire logic cfgAck,
  input wire logic defaultLoad,
  input wire logic [switch_cfg_pkg::ADDR_W-1:0] defaultAddr,
  input wire logic [31:0] defaultData,
  input wire logic [switch_cfg_pkg::GPIO_N-1:0] gpioPinOut,
  input wire logic [switch_cfg_pkg::GPIO_N-1:0] gpioPinOe,
  input wire logic [switch_cfg_pkg::REFCLK_N-1:0] refClkOutEnable,
  input wire logic portDisable,
  input wire logic [7:0] extraPhyControlByte
);
  import switch_cfg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_ld(a);
    defaultLoad && defaultAddr == a;
  endsequence
  sequence s_rd(a);
    cfgReq && !cfgWrite && cfgAddr == a;
  endsequence
  chk_ack_next: assert property (cfgReq |=> cfgAck) else $error("ack missing");
  chk_ack_spurious: assert property (!cfgReq |=> !cfgAck) else $error("stray ack");
  chk_out_gated:
    assert property ((gpioPinOut & ~gpioPinOe) == 8'h00) else $error("pin driven while off");
  chk_cap_read:
    assert property (s_rd(8'hb0) |=> cfgRdata == 32'h0000_c00d) else $error("bad cap header");
  chk_write_zero:
    assert property (cfgReq && cfgWrite |=> cfgRdata == 32'h0) else $error("write data nonzero");
  chk_clk_global:
    assert property (s_ld(8'h98) ##0 defaultData[20] |-> ##2 refClkOutEnable == 4'h0)
      else $error("clocks not off");
  chk_clk_each:
    assert property (s_ld(8'h98) ##0 !defaultData[20]
      |-> ##2 refClkOutEnable == $past(defaultData[19:16], 2)) else $error("clock gate wrong");
  chk_port_off:
    assert property (s_ld(8'h8c) |-> ##2 portDisable == $past(defaultData[10], 2))
      else $error("port disable wrong");
  chk_extra_byte:
    assert property (s_ld(8'h8c) |-> ##2 extraPhyControlByte == $past(defaultData[23:16], 2))
      else $error("extra byte wrong");
  chk_gpio_write:
    assert property (IS_UPSTREAM && cfgReq && cfgWrite && cfgAddr == 8'hb8 && cfgByteEn[3]
      |-> ##2 gpioPinOe[7] == $past(cfgWdata[29], 2)) else $error("pin 7 enable wrong");
  chk_rst_idle:
    assert property (disable iff (1'b0) sys_rst |=> gpioPinOe == 8'h00 && gpioPinOut == 8'h00)
      else $error("pins active after reset");
endmodule
bind switch_port_config_gpio_regs switch_port_config_gpio_regs_chk #(.IS_UPSTREAM(IS_UPSTREAM))
  chk_inst (.clk, .sys_rst, .cfgReq, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWdata, .cfgRdata,
  .cfgAck, .defaultLoad, .defaultAddr, .defaultData, .gpioPinOut, .gpioPinOe,
  .refClkOutEnable, .portDisable, .extraPhyControlByte);

//--- switch_port_config_gpio_regs_tb_top.sv
`timescale 1ns/1ps
module switch_port_config_gpio_regs_tb_top;
  import switch_cfg_pkg::*;
  logic clk = 0, sys_rst = 1, cfgReq = 0, cfgWrite = 0, defaultLoad = 0;
  logic clockBufferPowerdownStrap = 0, cfgAck, portDisable, relaxedOrderingOff, resetSelect;
  logic [7:0] cfgAddr = 0, defaultAddr = 0, gpioPinIn = 8'h81;
  logic [7:0] gpioPinOut, gpioPinOe, extraPhyControlByte;
  logic [3:0] cfgByteEn = 4'hf, refClkOutEnable;
  logic [31:0] cfgWdata = 0, defaultData = 0, cfgRdata, q;
  logic [8:0] modePins = 9'h1a5;
  logic [1:0] rateChangeAttemptCount;
  int n_mismatch = 0, n_compared = 0;
  switch_port_config_gpio_regs switch_port_config_gpio_regs_inst (.clk, .sys_rst, .cfgReq,
    .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWdata, .cfgRdata, .cfgAck, .defaultLoad, .defaultAddr,
    .defaultData, .clockBufferPowerdownStrap, .modePins, .gpioPinIn, .gpioPinOut, .gpioPinOe,
    .refClkOutEnable, .portDisable, .relaxedOrderingOff, .resetSelect, .rateChangeAttemptCount,
    .extraPhyControlByte);
  initial forever #5 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Request is a one-cycle pulse; the answer lands in the following cycle
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    int i;
    cfgReq = 1;
    cfgWrite = wr;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWdata = d;
    @(negedge clk);
    cfgReq = 0;
    i = 0;
    while (cfgAck !== 1'b1 && i < 4) begin
      @(negedge clk);
      i++;
    end
    if (cfgAck !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    q = cfgRdata;
    @(negedge clk);
  endtask
  // Outputs lag the register by a clock, so settle two cycles
  task automatic ld(input logic [7:0] a, input logic [31:0] d);
    defaultLoad = 1;
    defaultAddr = a;
    defaultData = d;
    @(negedge clk);
    defaultLoad = 0;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_reset();
    logic [7:0] a [8] = '{8'h8c, 8'h90, 8'h94, 8'h98, 8'hb0, 8'hb4, 8'hb8, 8'ha0};
    logic [31:0] e [8] = '{32'h0079_0010, 32'h0000_8000, 32'h0086_116b, 32'h000f_01a5,
                           32'h0000_c00d, 32'h0, 32'h1000_0001, 32'h0};
    for (int i = 0; i < 8; i++) begin
      cfg(0, a[i], 4'hf, 0);
      chk($sformatf("word %h", a[i]), e[i], q);
    end
    chk("clock enables", 32'hf, refClkOutEnable);
  endtask
  task automatic t_gpio();
    cfg(1, 8'hb8, 4'hf, 32'hffff_ffff);
    cfg(0, 8'hb8, 4'hf, 0);
    chk("gpio word", 32'h7666_6667, q);
    chk("pin enables", 32'hff, gpioPinOe);
    chk("pin values", 32'hff, gpioPinOut);
    cfg(1, 8'hb8, 4'h1, 32'h0000_0002);
    gpioPinIn = 8'h02;
    repeat (4) @(negedge clk);
    cfg(0, 8'hb8, 4'hf, 0);
    chk("gpio word", 32'h6666_6612, q);
    chk("pin enables", 32'hfd, gpioPinOe);
    chk("pin values", 32'hfc, gpioPinOut);
  endtask
  task automatic t_tl();
    cfg(1, 8'h8c, 4'hf, 32'hffff_ffff);
    cfg(0, 8'h8c, 4'hf, 0);
    chk("tl word", 32'h0079_0070, q);
    chk("ordering off", 32'h1, relaxedOrderingOff);
    ld(8'h8c, 32'hffff_ffff);
    cfg(0, 8'h8c, 4'hf, 0);
    chk("tl word", 32'hbfff_1fff, q);
    chk("tl outputs", 32'hfff, {portDisable, resetSelect, rateChangeAttemptCount,
        extraPhyControlByte});
  endtask
  task automatic t_loads();
    ld(8'h98, 32'h0015_0000);
    chk("clock enables", 32'h0, refClkOutEnable);
    ld(8'h98, 32'h0005_0000);
    chk("clock enables", 32'h5, refClkOutEnable);
    ld(8'hb4, 32'h1234_abcd);
    cfg(1, 8'hb4, 4'hf, 32'h0);
    cfg(0, 8'hb4, 4'hf, 0);
    chk("subsystem codes", 32'h1234_abcd, q);
  endtask
  // Mid-run reset with the strap high: loaded defaults give way to reset values
  task automatic t_strap();
    clockBufferPowerdownStrap = 1;
    repeat (2) @(negedge clk);
    sys_rst = 1;
    repeat (2) @(negedge clk);
    sys_rst = 0;
    @(negedge clk);
    cfg(0, 8'h98, 4'hf, 0);
    chk("mode word", 32'h001f_01a5, q);
    chk("clock enables", 32'h0, refClkOutEnable);
    chk("pin enables", 32'h0, gpioPinOe);
    cfg(0, 8'h8c, 4'hf, 0);
    chk("tl word", 32'h0079_0010, q);
  endtask
  initial begin
    // Two edges in reset; the strap is taken again on the first clock after it
    repeat (2) @(negedge clk);
    sys_rst = 0;
    @(negedge clk);
    t_reset();
    t_gpio();
    t_tl();
    t_loads();
    t_strap();
    stop_test();
  end
endmodule
